// file: counter_pkg.sv
// Shared constants, field positions and types for the 24-bit multimode counter
// Overview of operation
// - Status read puts five bits on D0-D4
// - Toggles flip on underflow, overflow, preset match
// - Sign sets on underflow, clears on overflow/reset
// - Bit 4 shows quadrature direction, else one
// - Three preset bytes load counter at once
// - Snapshot captures counter, bytes read singly
// - Master bits: pointer, snapshot, clears, load
// - Master reset: preset and direction to ones, clear all else but the byte pointer
// - Input mode: up/down pair or count+direction
// - Input setup write steps counter once
// - Input setup bit gates external count inputs
// - Gate pin acts as reset or gate
// - Load pin loads counter or snapshot
// - Binary, BCD, divide-by-N, 24-hour select
// - Single-cycle mode inhibits after carry/borrow
// - Output select picks pulses, toggles, compare
// - Quadrature x4 counting, enabled by both bits
// - Control write: top two bits pick register
// - Data access uses byte pointer, status read
package counter_pkg;
    // Counter geometry
    localparam int CNT_W = 24;
    localparam int BYTE_W = 8;
    localparam int CTRL_W = 6;
    localparam int QUAD_W = 2;
    localparam int STATUS_W = 5;
    localparam int DIGITS = 6;
    localparam int HOUR_DIGIT = 4;
    // Reset and bound values
    localparam logic [CNT_W-1:0] LOAD_RESET = 24'hffffff;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] TENS_MAX = 4'h5;
    localparam logic [7:0] HOUR_MAX = 8'h23;
    localparam logic [1:0] PTR_LAST = 2'h2;
    // Control register select in data bits 7:6
    localparam int SEL_HI = 7;
    localparam int SEL_LO = 6;
    localparam logic [1:0] SEL_MASTER = 2'h0;
    localparam logic [1:0] SEL_INPUT = 2'h1;
    localparam logic [1:0] SEL_OUTPUT = 2'h2;
    localparam logic [1:0] SEL_QUAD = 2'h3;
    // Master command bits
    localparam int MC_PTR_CLR = 0;
    localparam int MC_SNAP = 1;
    localparam int MC_FLAG_CLR = 2;
    localparam int MC_LOAD = 3;
    localparam int MC_MATCH_CLR = 4;
    localparam int MC_MASTER_RST = 5;
    // Input setup bits
    localparam int IN_AB_MODE = 0;
    localparam int IN_INC = 1;
    localparam int IN_DEC = 2;
    localparam int IN_AB_EN = 3;
    localparam int IN_GATE_ROLE = 4;
    localparam int IN_LOAD_ROLE = 5;
    // Output/count setup bits
    localparam int OUT_BCD = 0;
    localparam int OUT_SINGLE = 1;
    localparam int OUT_DIVN = 2;
    localparam int OUT_HOUR = 3;
    localparam int OUT_SEL_LO = 4;
    localparam int OUT_SEL_HI = 5;
    // Quadrature enable bits
    localparam int QUAD_D0 = 0;
    localparam int QUAD_D1 = 1;
    // Status bit positions
    localparam int ST_BORROW_T = 0;
    localparam int ST_CARRY_T = 1;
    localparam int ST_MATCH_T = 2;
    localparam int ST_SIGN = 3;
    localparam int ST_DIR = 4;
    // Event output selection
    typedef enum logic [1:0] {EV_LOW_PULSE, EV_TOGGLES, EV_HIGH_PULSE, EV_COMPARE} event_sel_t;
endpackage

// file: pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] RESET_VAL = '0
)(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_sync_out
);
    logic [W-1:0] stage1_reg; // First stage, read only by second

    // Two flip-flops per pin
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            stage1_reg <= RESET_VAL;
            pin_sync_out <= RESET_VAL;
        end
        else
        begin
            stage1_reg <= pin_in;
            pin_sync_out <= stage1_reg;
        end
    end
endmodule

// file: count_step.sv
// Next-value arithmetic for binary, BCD, 24-hour and divide-by-N counting
`timescale 1ns/1ps
module count_step #(
    parameter int W = counter_pkg::CNT_W
)(
    input wire logic [W-1:0] value,
    input wire logic [W-1:0] limit,
    input wire logic up,
    input wire logic dn,
    input wire logic bcd,
    input wire logic hour,
    input wire logic divn,
    output logic [W-1:0] next,
    output logic carry,
    output logic borrow
);
    // Largest digit value for a decimal position
    function automatic logic [3:0] digit_max(input int i, input logic hr);
        digit_max = (hr && (i % 2 == 1)) ? counter_pkg::TENS_MAX : counter_pkg::DIGIT_MAX;
    endfunction

    // Decimal increment, returns {carry, value}
    function automatic logic [W:0] dec_up(input logic [W-1:0] v, input logic hr);
        logic [W-1:0] r;
        logic c;
        logic [7:0] h;
        r = v;
        c = 1'b1;
        for (int i = 0; i < counter_pkg::DIGITS; i++)
        begin
            if (c && !(hr && i >= counter_pkg::HOUR_DIGIT))
            begin
                if (v[i*4 +: 4] >= digit_max(i, hr))
                    r[i*4 +: 4] = 4'h0;
                else
                begin
                    r[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        // Hours pair wraps after 23
        h = v[W-1 -: 8];
        if (c && hr)
        begin
            if (h >= counter_pkg::HOUR_MAX)
                r[W-1 -: 8] = 8'h00;
            else
            begin
                c = 1'b0;
                r[W-1 -: 8] = (h[3:0] >= counter_pkg::DIGIT_MAX) ? {h[7:4] + 4'h1, 4'h0} : h + 8'h01;
            end
        end
        dec_up = {c, r};
    endfunction

    // Decimal decrement, returns {borrow, value}
    function automatic logic [W:0] dec_down(input logic [W-1:0] v, input logic hr);
        logic [W-1:0] r;
        logic b;
        logic [7:0] h;
        r = v;
        b = 1'b1;
        for (int i = 0; i < counter_pkg::DIGITS; i++)
        begin
            if (b && !(hr && i >= counter_pkg::HOUR_DIGIT))
            begin
                if (v[i*4 +: 4] == 4'h0)
                    r[i*4 +: 4] = digit_max(i, hr);
                else
                begin
                    r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                    b = 1'b0;
                end
            end
        end
        // Hours pair wraps below zero to 23
        h = v[W-1 -: 8];
        if (b && hr)
        begin
            if (h == 8'h00)
                r[W-1 -: 8] = counter_pkg::HOUR_MAX;
            else
            begin
                b = 1'b0;
                r[W-1 -: 8] = (h[3:0] == 4'h0) ? {h[7:4] - 4'h1, counter_pkg::DIGIT_MAX} : h - 8'h01;
            end
        end
        dec_down = {b, r};
    endfunction

    // One step in the selected mode, wrapping at its bounds
    always_comb
    begin
        next = value;
        carry = 1'b0;
        borrow = 1'b0;
        if (up && !dn)
        begin
            if (divn)
            begin
                carry = (value >= limit);
                next = carry ? '0 : value + 1'b1;
            end
            else if (bcd || hour)
                {carry, next} = dec_up(value, hour);
            else
            begin
                carry = &value;
                next = value + 1'b1;
            end
        end
        else if (dn && !up)
        begin
            borrow = (value == '0);
            if (divn)
                next = borrow ? limit : value - 1'b1;
            else if (bcd || hour)
                {borrow, next} = dec_down(value, hour);
            else
                next = value - 1'b1;
        end
    end
endmodule

// file: multimode_counter.sv
// Top level of the 24-bit multimode counter with its byte-wide processor port
`timescale 1ns/1ps
module multimode_counter_24bit #(
    parameter int CNT_W = counter_pkg::CNT_W
)(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic control_data_select,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic count_a,
    input wire logic count_b,
    input wire logic gate_or_clear_pin_n,
    input wire logic load_select_pin_n,
    output logic overflow_out,
    output logic underflow_out
);
    // Synchronised pin images
    logic [15:0] pins_s;
    logic cs_s, rd_s, wr_s, cd_s, a_s, b_s, gate_s, load_s;
    logic [7:0] data_s;
    // Previous synchronised levels for edge detection
    logic wr_prev_reg, rd_prev_reg, a_prev_reg, b_prev_reg, load_prev_reg;
    // Register file
    logic [CNT_W-1:0] load_value_reg;
    logic [CNT_W-1:0] snapshot_reg;
    logic [CNT_W-1:0] count_core;
    logic [counter_pkg::CTRL_W-1:0] input_setup_reg;
    logic [counter_pkg::CTRL_W-1:0] output_count_setup_reg;
    logic [counter_pkg::QUAD_W-1:0] quad_enable_reg;
    logic [1:0] byte_ptr_reg;
    // Status flags
    logic underflow_toggle, overflow_toggle, match_toggle, sign_reg, dir_reg;
    logic [counter_pkg::STATUS_W-1:0] status_flags;
    // Counting state
    logic inhibit_reg;
    logic match_prev_reg;
    // Decoded events
    logic wr_done, rd_done, ctl_wr, data_wr;
    logic [1:0] ctl_sel;
    logic master_wr, input_wr, output_wr, quad_wr, master_rst;
    logic load_pin_fall, load_evt, snap_evt, clear_evt;
    logic quad_on, ext_en, ext_clear, a_rise, b_rise, quad_chg, quad_up;
    logic up_ext, dn_ext, step_up, step_dn;
    logic [CNT_W-1:0] step_next;
    logic step_carry, step_borrow, carry_evt, borrow_evt, cmp_eq;
    counter_pkg::event_sel_t ev_sel;

    // Every pin passes two flip-flops; strobes and active-low pins idle high, no false edge after reset
    pin_sync #(
        .W(16),
        .RESET_VAL(16'hf300)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_in({cs_n, rd_n, wr_n, control_data_select, count_a, count_b, gate_or_clear_pin_n,
                 load_select_pin_n, data_in}),
        .pin_sync_out(pins_s)
    );
    assign {cs_s, rd_s, wr_s, cd_s, a_s, b_s, gate_s, load_s, data_s} = pins_s;

    // Edge history of the synchronised strobes and count inputs
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            wr_prev_reg <= 1'b1;
            rd_prev_reg <= 1'b1;
            a_prev_reg <= 1'b0;
            b_prev_reg <= 1'b0;
            load_prev_reg <= 1'b1;
        end
        else
        begin
            wr_prev_reg <= wr_s;
            rd_prev_reg <= rd_s;
            a_prev_reg <= a_s;
            b_prev_reg <= b_s;
            load_prev_reg <= load_s;
        end
    end

    // Bus decode: accesses complete at the rising end of the strobe
    assign wr_done = wr_s & ~wr_prev_reg & ~cs_s;
    assign rd_done = rd_s & ~rd_prev_reg & ~cs_s & ~cd_s;
    assign ctl_wr = wr_done & cd_s;
    assign data_wr = wr_done & ~cd_s;
    assign ctl_sel = data_s[counter_pkg::SEL_HI:counter_pkg::SEL_LO];
    assign master_wr = ctl_wr && (ctl_sel == counter_pkg::SEL_MASTER);
    assign input_wr = ctl_wr && (ctl_sel == counter_pkg::SEL_INPUT);
    assign output_wr = ctl_wr && (ctl_sel == counter_pkg::SEL_OUTPUT);
    assign quad_wr = ctl_wr && (ctl_sel == counter_pkg::SEL_QUAD);
    assign master_rst = master_wr & data_s[counter_pkg::MC_MASTER_RST];

    // Load pin role and command sources
    assign load_pin_fall = ~load_s & load_prev_reg;
    assign load_evt = (master_wr & data_s[counter_pkg::MC_LOAD])
                      | (load_pin_fall & ~input_setup_reg[counter_pkg::IN_LOAD_ROLE]);
    assign snap_evt = (master_wr & data_s[counter_pkg::MC_SNAP])
                      | (load_pin_fall & input_setup_reg[counter_pkg::IN_LOAD_ROLE]);

    // Gate pin role: active-low reset or active-low enable gate
    assign ext_clear = ~input_setup_reg[counter_pkg::IN_GATE_ROLE] & ~gate_s;
    assign ext_en = input_setup_reg[counter_pkg::IN_AB_EN]
                    & (~input_setup_reg[counter_pkg::IN_GATE_ROLE] | ~gate_s);
    assign clear_evt = master_rst | ext_clear;

    // Count input decode, normal and x4 quadrature
    assign quad_on = quad_enable_reg[counter_pkg::QUAD_D0] & quad_enable_reg[counter_pkg::QUAD_D1];
    assign a_rise = a_s & ~a_prev_reg;
    assign b_rise = b_s & ~b_prev_reg;
    assign quad_chg = (a_s ^ a_prev_reg) ^ (b_s ^ b_prev_reg);
    assign quad_up = a_s ^ b_prev_reg;

    always_comb
    begin
        up_ext = 1'b0;
        dn_ext = 1'b0;
        if (quad_on)
        begin
            // One count per edge of either input
            up_ext = quad_chg & quad_up;
            dn_ext = quad_chg & ~quad_up;
        end
        else if (input_setup_reg[counter_pkg::IN_AB_MODE])
        begin
            // First input counts, second gives direction
            up_ext = a_rise & ~b_s;
            dn_ext = a_rise & b_s;
        end
        else
        begin
            // Separate up and down inputs
            up_ext = a_rise;
            dn_ext = b_rise;
        end
    end

    // Count requests from pins and single-step writes
    assign step_up = ~inhibit_reg & ((ext_en & up_ext) | (input_wr & data_s[counter_pkg::IN_INC]));
    assign step_dn = ~inhibit_reg & ((ext_en & dn_ext) | (input_wr & data_s[counter_pkg::IN_DEC]));

    // Mode arithmetic
    count_step #(
        .W(CNT_W)
    ) u_step (
        .value(count_core),
        .limit(load_value_reg),
        .up(step_up),
        .dn(step_dn),
        .bcd(output_count_setup_reg[counter_pkg::OUT_BCD]),
        .hour(output_count_setup_reg[counter_pkg::OUT_HOUR]),
        .divn(output_count_setup_reg[counter_pkg::OUT_DIVN]),
        .next(step_next),
        .carry(step_carry),
        .borrow(step_borrow)
    );

    // Carry or borrow only when the step actually lands
    assign carry_evt = step_carry & ~clear_evt & ~load_evt;
    assign borrow_evt = step_borrow & ~clear_evt & ~load_evt;
    assign cmp_eq = (count_core == load_value_reg);

    // Counter: reset, then load, then step
    always_ff @(posedge ref_clk)
    begin
        if (reset || clear_evt)
            count_core <= '0;
        else if (load_evt)
            count_core <= load_value_reg;
        else
            count_core <= step_next;
    end

    // Single-cycle inhibit after the first carry or borrow
    always_ff @(posedge ref_clk)
    begin
        if (reset || clear_evt || load_evt)
            inhibit_reg <= 1'b0;
        else if (output_count_setup_reg[counter_pkg::OUT_SINGLE] && (carry_evt || borrow_evt))
            inhibit_reg <= 1'b1;
    end

    // Preset bytes written through the byte pointer
    always_ff @(posedge ref_clk)
    begin
        if (reset || master_rst)
            load_value_reg <= counter_pkg::LOAD_RESET;
        else if (data_wr)
            load_value_reg[byte_ptr_reg*counter_pkg::BYTE_W +: counter_pkg::BYTE_W] <= data_s;
    end

    // Snapshot of the counter
    always_ff @(posedge ref_clk)
    begin
        if (reset || master_rst)
            snapshot_reg <= '0;
        else if (snap_evt)
            snapshot_reg <= count_core;
    end

    // Byte pointer: cleared by command, advanced by data accesses
    always_ff @(posedge ref_clk)
    begin
        if (reset || (master_wr && data_s[counter_pkg::MC_PTR_CLR]))
            byte_ptr_reg <= 2'h0;
        else if (data_wr || rd_done)
            byte_ptr_reg <= (byte_ptr_reg == counter_pkg::PTR_LAST) ? 2'h0 : byte_ptr_reg + 2'h1;
    end

    // Control registers, all cleared by master reset
    always_ff @(posedge ref_clk)
    begin
        if (reset || master_rst)
        begin
            input_setup_reg <= '0;
            output_count_setup_reg <= '0;
            quad_enable_reg <= '0;
        end
        else
        begin
            if (input_wr)
                input_setup_reg <= data_s[counter_pkg::CTRL_W-1:0];
            if (output_wr)
                output_count_setup_reg <= data_s[counter_pkg::CTRL_W-1:0];
            if (quad_wr)
                quad_enable_reg <= data_s[counter_pkg::QUAD_W-1:0];
        end
    end

    // Underflow and overflow toggles; an event beats a same-cycle clear
    always_ff @(posedge ref_clk)
    begin
        if (reset || master_rst)
        begin
            underflow_toggle <= 1'b0;
            overflow_toggle <= 1'b0;
        end
        else if (master_wr && data_s[counter_pkg::MC_FLAG_CLR])
        begin
            underflow_toggle <= borrow_evt;
            overflow_toggle <= carry_evt;
        end
        else
        begin
            underflow_toggle <= underflow_toggle ^ borrow_evt;
            overflow_toggle <= overflow_toggle ^ carry_evt;
        end
    end

    // Sign flag
    always_ff @(posedge ref_clk)
    begin
        if (reset || clear_evt)
            sign_reg <= 1'b0;
        else if (borrow_evt)
            sign_reg <= 1'b1;
        else if (carry_evt || (master_wr && data_s[counter_pkg::MC_FLAG_CLR]))
            sign_reg <= 1'b0;
    end

    // Match toggle on each new equality with the preset
    always_ff @(posedge ref_clk)
    begin
        if (reset || master_rst)
        begin
            match_toggle <= 1'b0;
            match_prev_reg <= 1'b0;
        end
        else
        begin
            match_prev_reg <= cmp_eq;
            if (master_wr && data_s[counter_pkg::MC_MATCH_CLR])
                match_toggle <= cmp_eq & ~match_prev_reg;
            else if (cmp_eq && !match_prev_reg)
                match_toggle <= ~match_toggle;
        end
    end

    // Quadrature direction indicator
    always_ff @(posedge ref_clk)
    begin
        if (reset || master_rst)
            dir_reg <= 1'b1;
        else if (quad_on && quad_chg)
            dir_reg <= quad_up;
    end

    // Status word
    always_comb
    begin
        status_flags = '0;
        status_flags[counter_pkg::ST_BORROW_T] = underflow_toggle;
        status_flags[counter_pkg::ST_CARRY_T] = overflow_toggle;
        status_flags[counter_pkg::ST_MATCH_T] = match_toggle;
        status_flags[counter_pkg::ST_SIGN] = sign_reg;
        status_flags[counter_pkg::ST_DIR] = quad_on ? dir_reg : 1'b1;
    end

    // Read data path, driven while chip select and read are low
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            data_oe <= 1'b0;
            data_out <= 8'h00;
        end
        else
        begin
            data_oe <= ~cs_s & ~rd_s;
            if (cd_s)
                data_out <= {{(8-counter_pkg::STATUS_W){1'b0}}, status_flags};
            else
                data_out <= snapshot_reg[byte_ptr_reg*counter_pkg::BYTE_W +: counter_pkg::BYTE_W];
        end
    end

    // Event output selection
    assign ev_sel = counter_pkg::event_sel_t'(output_count_setup_reg[counter_pkg::OUT_SEL_HI:counter_pkg::OUT_SEL_LO]);

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            overflow_out <= 1'b1;
            underflow_out <= 1'b1;
        end
        else
        begin
            unique case (ev_sel)
                counter_pkg::EV_LOW_PULSE:
                begin
                    overflow_out <= ~carry_evt;
                    underflow_out <= ~borrow_evt;
                end
                counter_pkg::EV_TOGGLES:
                begin
                    overflow_out <= overflow_toggle;
                    underflow_out <= underflow_toggle;
                end
                counter_pkg::EV_HIGH_PULSE:
                begin
                    overflow_out <= carry_evt;
                    underflow_out <= borrow_evt;
                end
                counter_pkg::EV_COMPARE:
                begin
                    overflow_out <= ~cmp_eq;
                    underflow_out <= match_toggle;
                end
            endcase
        end
    end
endmodule

// file: counter_chk.sv
// Port-level assertions for the 24-bit multimode counter
`timescale 1ns/1ps
module counter_chk #(
    parameter int CNT_W = counter_pkg::CNT_W
)(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic control_data_select,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic overflow_out,
    input wire logic underflow_out
);
    // Single clock domain
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    rd_fill_a: assert property ((!cs_n && !rd_n) [*5] |-> data_oe)
        else $error("bus not driven during read");
    rd_quiet_a: assert property (rd_n [*5] |-> !data_oe)
        else $error("bus driven without read");
    cs_quiet_a: assert property (cs_n [*5] |-> !data_oe)
        else $error("bus driven while deselected");
    oe_cause_a: assert property ($rose(data_oe) |-> !$past(rd_n, 1) && !$past(rd_n, 2))
        else $error("drive without read strobe");
    oe_select_a: assert property (data_oe |-> !$past(cs_n, 2))
        else $error("drive without chip select");
    oe_hold_a: assert property (data_oe && !rd_n && !cs_n |=> data_oe)
        else $error("drive dropped during read");
    status_top_a: assert property ((!cs_n && !rd_n && control_data_select) [*5] |-> data_out[7:5] == 3'h0)
        else $error("status upper bits not zero");
    event_idle_a: assert property ($fell(reset) |-> overflow_out && underflow_out)
        else $error("event outputs not idle high");
    bus_idle_a: assert property ($fell(reset) |-> !data_oe && data_out == 8'h00)
        else $error("bus not idle after reset");
endmodule
bind multimode_counter_24bit counter_chk #(.CNT_W(CNT_W)) counter_chk_i (.ref_clk, .reset, .cs_n, .rd_n,
    .control_data_select, .data_out, .data_oe, .overflow_out, .underflow_out);

// file: host_bus.sv
// Host processor model on the byte-wide bus
`timescale 1ns/1ps
module host_bus (
    input wire logic ref_clk,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic control_data_select,
    output logic [7:0] data_in
);
    // Idle: deselected, strobes high
    initial
    begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        control_data_select = 1'b1;
        data_in = 8'h00;
    end
    // One strobe; select and data held well past the rising strobe
    task automatic access(input logic wr, input logic cds, input logic [7:0] d);
        @(posedge ref_clk);
        cs_n <= 1'b0;
        control_data_select <= cds;
        data_in <= d;
        wr_n <= !wr;
        rd_n <= wr;
        repeat (5) @(posedge ref_clk);
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        cs_n <= 1'b1;
        data_in <= ~d; // Released bus holds no stale value
    endtask
endmodule

// file: tb_top.sv
// Self-checking bench for the 24-bit multimode counter
`timescale 1ns/1ps
module tb_top;
    logic ref_clk, reset, cs_n, rd_n, wr_n, control_data_select, data_oe;
    logic [7:0] data_in, data_out, want;
    logic count_a, count_b, gate_or_clear_pin_n, load_select_pin_n, overflow_out, underflow_out;
    logic [7:0] expq[$]; // Expected read bytes, oldest first
    logic [23:0] val;
    int failures, n_compared, cycles, oe_cnt, n, seed;
    multimode_counter_24bit multimode_counter_24bit_i (.ref_clk, .reset, .cs_n, .rd_n, .wr_n,
        .control_data_select, .data_in, .data_out, .data_oe, .count_a, .count_b, .gate_or_clear_pin_n,
        .load_select_pin_n, .overflow_out, .underflow_out);
    host_bus host_bus_i (.ref_clk, .cs_n, .rd_n, .wr_n, .control_data_select, .data_in);
    // 125 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Prints counts and verdict, ends run
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            failures++;
            give_verdict();
        end
    end
    // Compares each read once the bus has settled
    always @(posedge ref_clk)
    begin
        oe_cnt = (data_oe === 1'b1) ? oe_cnt + 1 : 0;
        if (oe_cnt == 2)
        begin
            n_compared++;
            want = expq.size() > 0 ? expq.pop_front() : 8'hxx;
            if (data_out !== want)
            begin
                failures++;
                $display("unexpected at %0t: read %h want %h", $time, data_out, want);
            end
        end
    end
    task automatic wr(input logic [7:0] d, input logic c = 1'b1);
        host_bus_i.access(1'b1, c, d);
    endtask
    task automatic status(input logic [4:0] s);
        expq.push_back({3'h0, s});
        host_bus_i.access(1'b0, 1'b1, 8'h00);
    endtask
    // Checks the two event outputs after they settle
    task automatic evt(input logic [1:0] e);
        repeat (4) @(posedge ref_clk);
        n_compared++;
        if ({overflow_out, underflow_out} !== e)
        begin
            failures++;
            $display("unexpected at %0t: events %b want %b", $time, {overflow_out, underflow_out}, e);
        end
    endtask
    // Snapshot the counter (or only reset the pointer) and read its three bytes
    task automatic snap(input logic [23:0] v, input logic [7:0] cmd = 8'h03);
        wr(cmd);
        for (int i = 0; i < 3; i++)
        begin
            expq.push_back(v[8*i +: 8]);
            host_bus_i.access(1'b0, 1'b0, 8'h00);
        end
    endtask
    // Write the three preset bytes, then load the counter
    task automatic preset(input logic [23:0] v);
        wr(8'h01);
        for (int i = 0; i < 3; i++)
            wr(v[8*i +: 8], 1'b0);
        wr(8'h08);
    endtask
    // Toggle count_a (b=0) or count_b (b=1), then settle
    task automatic flip(input logic b);
        @(posedge ref_clk);
        count_a <= count_a ^ !b;
        count_b <= count_b ^ b;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic pulses(input logic b, input int k);
        repeat (2 * k) flip(b);
    endtask
    // Main sequence
    initial
    begin
        seed = 32'h31df1945;
        reset = 1'b1;
        count_a = 1'b0;
        count_b = 1'b0;
        gate_or_clear_pin_n = 1'b1;
        load_select_pin_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        status(5'h10);
        val = $random(seed);
        preset(val);
        snap(val);
        wr(8'h42);
        snap(val + 24'h1);
        $display("test load finished");
        wr(8'h20);
        wr(8'h44);
        status(5'h1d);
        wr(8'h90);
        evt(2'b01);
        snap(24'hffffff);
        wr(8'h42);
        status(5'h17);
        evt(2'b11);
        wr(8'h04);
        status(5'h14);
        evt(2'b00);
        wr(8'hb0);
        wr(8'h10);
        status(5'h10);
        evt(2'b10);
        wr(8'h44);
        evt(2'b01);
        wr(8'ha0);
        evt(2'b00);
        wr(8'h2a);
        snap(24'h0);
        evt(2'b11);
        $display("test flags finished");
        n = $unsigned($random(seed)) % 8;
        wr(8'h48);
        pulses(1'b0, n + 2);
        pulses(1'b1, 2);
        snap(24'(n));
        wr(8'h58);
        pulses(1'b0, 3);
        snap(24'(n));
        gate_or_clear_pin_n <= 1'b0;
        pulses(1'b0, 1);
        snap(24'(n + 1));
        wr(8'h48);
        snap(24'h0);
        gate_or_clear_pin_n <= 1'b1;
        wr(8'h49);
        flip(1'b0);
        flip(1'b1);
        flip(1'b0);
        pulses(1'b0, 2);
        snap(24'hffffff);
        $display("test inputs finished");
        wr(8'h20);
        flip(1'b1);
        wr(8'hc3);
        wr(8'h48);
        for (int i = 0; i < 4; i++)
            flip(i[0]);
        snap(24'h4);
        status(5'h10);
        for (int i = 0; i < 4; i++)
            flip(!i[0]);
        status(5'h00);
        wr(8'h40);
        load_select_pin_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        load_select_pin_n <= 1'b1;
        snap(24'hffffff);
        wr(8'h62);
        load_select_pin_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        load_select_pin_n <= 1'b1;
        snap(24'h0, 8'h01);
        $display("test quadrature finished");
        wr(8'h81);
        wr(8'h44);
        snap(24'h999999);
        wr(8'h83);
        wr(8'h42);
        wr(8'h42);
        snap(24'h0);
        $display("test modes finished");
        give_verdict();
    end
endmodule
